/* File: design/fsc_conv_timer.sv */
`timescale 1ns/1ps
module fsc_conv_timer
  import fsc_pkg::*;
#(
  parameter int CNT_W = 20,
  parameter int T0 = us_to_cycles(SAMPLE_US[0]),
  parameter int T1 = us_to_cycles(SAMPLE_US[1]),
  parameter int T2 = us_to_cycles(SAMPLE_US[2]),
  parameter int T3 = us_to_cycles(SAMPLE_US[3]),
  parameter int T4 = us_to_cycles(SAMPLE_US[4]),
  parameter int T5 = us_to_cycles(SAMPLE_US[5]),
  parameter int T6 = us_to_cycles(SAMPLE_US[6])
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Control
  input  wire logic             start,
  input  wire logic [2:0]       mode,
  // Status
  output logic                  busy,
  output logic                  done
);
  // Slowest mode must fit the counter; a zero length would wrap and run a full counter period
  if (T6 >= (1 << CNT_W) || T0 < 1) begin : g_cnt_chk
    $error("fsc_conv_timer: counter too narrow");
  end

  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             busy_reg, busy_next;
  logic             done_reg, done_next;
  logic [CNT_W-1:0] load;

  // Mode selects the sampling duration
  always_comb begin
    unique case (mode)
      3'd0: load = CNT_W'(T0);
      3'd1: load = CNT_W'(T1);
      3'd2: load = CNT_W'(T2);
      3'd3: load = CNT_W'(T3);
      3'd4: load = CNT_W'(T4);
      3'd5: load = CNT_W'(T5);
      default: load = CNT_W'(T6);
    endcase
  end

  // Count down; start ignored while busy
  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (busy_reg) begin
      if (cnt_reg == CNT_W'(1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
      cnt_next = cnt_reg - CNT_W'(1);
    end else if (start) begin
      busy_next = 1'b1;
      cnt_next  = load;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
endmodule

/* File: design/fsc_core.sv */
`timescale 1ns/1ps
module fsc_core
  import fsc_pkg::*;
#(
  parameter int MAG_W  = MAG_BITS,
  parameter int TEMP_W = TEMP_BITS
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Serial pins
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              serial_command_in,
  output logic                   serial_reply_out,
  // ADC sample inputs
  input  wire logic [MAG_W-1:0]  adc_mag,
  input  wire logic [TEMP_W-1:0] adc_temp,
  // Status
  output logic [2:0]             osr_mode,
  output logic                   converting
);
  // Result packing below assumes the documented widths
  if (MAG_W != MAG_BITS || TEMP_W != TEMP_BITS) begin : g_width_chk
    $error("fsc_core: result width unsupported");
  end

  // Decode points, counted in sampled bits of a frame
  localparam logic [5:0] DECIDE_BIT = 6'(CMD_BITS - 2);  // Seventh rise, before bit 8
  localparam logic [5:0] ACK_BIT    = 6'(CMD_BITS);
  localparam logic [5:0] CFG_LAST   = 6'(CFG_BITS - 1);
  // Idle pins: deselected, clock low, data high
  localparam logic [2:0] PIN_IDLE   = 3'h5;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each before any logic

  logic [2:0] sync1_reg, sync2_reg;
  logic       sck_d_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= PIN_IDLE;  // No false select or clock edge after reset
      sync2_reg <= PIN_IDLE;
      sck_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {cs_n, sck, serial_command_in};
      sync2_reg <= sync1_reg;
      sck_d_reg <= sync2_reg[1];
    end
  end

  // Synchronised pins and serial clock edges
  logic cs_n_s, sck_s, din_s, sck_rise, sck_fall;
  assign cs_n_s   = sync2_reg[2];
  assign sck_s    = sync2_reg[1];
  assign din_s    = sync2_reg[0];
  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;

  ////////////////////////////////////////////////////////////////////////
  // Conversion timer

  // Mode is taken at start; a later config cannot stretch a run
  logic conv_start, conv_busy, conv_done;
  logic [2:0] mode_reg, mode_next;

  fsc_conv_timer u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (conv_start),
    .mode  (mode_reg),
    .busy  (conv_busy),
    .done  (conv_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Serial frame decoder

  fsc_state_t       st_reg, st_next;
  logic [5:0]       bit_reg, bit_next;    // Bits sampled in frame
  logic [23:0]      shin_reg, shin_next;  // Incoming bits
  logic [23:0]      shout_reg, shout_next;
  logic             dout_reg, dout_next;
  logic             ack_reg, ack_next;    // Acked start, hold low to done
  logic             is_cfg1_reg, is_cfg1_next;
  logic             tmp_kind_reg, tmp_kind_next;
  logic [MAG_W-1:0] mag_res_reg, mag_res_next;
  logic [TEMP_W-1:0] tmp_res_reg, tmp_res_next;
  logic [7:0]       cmd7;

  // Next values of the frame decoder
  always_comb begin
    st_next       = st_reg;
    bit_next      = bit_reg;
    shin_next     = shin_reg;
    shout_next    = shout_reg;
    dout_next     = dout_reg;
    ack_next      = ack_reg;
    is_cfg1_next  = is_cfg1_reg;
    tmp_kind_next = tmp_kind_reg;
    mode_next     = mode_reg;
    mag_res_next  = mag_res_reg;
    tmp_res_next  = tmp_res_reg;
    conv_start    = 1'b0;
    cmd7          = {shin_reg[5:0], din_s, 1'b0};

    // Latch result at end of conversion, release reply line
    if (conv_done) begin
      if (tmp_kind_reg) tmp_res_next = adc_temp;
      else              mag_res_next = adc_mag;
      ack_next = 1'b0;
    end

    if (cs_n_s) begin
      st_next   = FSC_IDLE;
      bit_next  = '0;
      dout_next = 1'b1;
      is_cfg1_next = 1'b0;  // A stale config flag must not act on a later frame
    end else begin
      if (st_reg == FSC_IDLE) st_next = FSC_CMD;
      if (sck_rise) begin
        shin_next = {shin_reg[22:0], din_s};
        // Saturate so an overlong frame is never decoded twice
        if (bit_reg != '1) bit_next = bit_reg + 6'd1;
        // Seven bits seen: decide acknowledge before bit 8 is driven
        if (bit_reg == DECIDE_BIT) begin
          unique case (cmd7[7:1])
            CMD_CONV_MAG[7:1], CMD_CONV_TEMP[7:1]: begin
              if (!conv_busy) begin
                conv_start    = 1'b1;
                ack_next      = 1'b1;
                tmp_kind_next = (cmd7 == CMD_CONV_TEMP);
                dout_next     = 1'b0;
              end
            end
            CMD_READ_MAG[7:1]: begin
              shout_next = mag_res_reg;
              dout_next  = 1'b0;
              st_next    = FSC_DATA;
            end
            CMD_READ_TEMP[7:1]: begin
              shout_next = {tmp_res_reg, 8'h00};
              dout_next  = 1'b0;
              st_next    = FSC_DATA;
            end
            CMD_CFG1[7:1], CMD_CFG2[7:1]: begin
              is_cfg1_next = (cmd7 == CMD_CFG1);
              dout_next    = conv_busy;
            end
            default: dout_next = 1'b1;
          endcase
        end
        // Full config frame: apply mode when idle
        if (bit_reg == CFG_LAST && is_cfg1_reg && !conv_busy) begin
          if (shin_next[7:0] <= OSR_MAX_ALT)
            mode_next = shin_next[2:0];
          else if (shin_next[7:0] == OSR_DEFAULT)
            mode_next = 3'(MODE_DEFAULT);
        end
      end
      // Shift result MSB first after the ack bit
      if (sck_fall && st_reg == FSC_DATA && bit_reg >= ACK_BIT) begin
        dout_next  = shout_reg[23];
        shout_next = {shout_reg[22:0], 1'b0};
      end else if (sck_fall && bit_reg == ACK_BIT && st_reg != FSC_DATA) begin
        dout_next = ~ack_reg;
      end
    end
  end

  // Decoder registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg       <= FSC_IDLE;
      bit_reg      <= '0;
      shin_reg     <= '0;
      shout_reg    <= '0;
      dout_reg     <= 1'b1;
      ack_reg      <= 1'b0;
      is_cfg1_reg  <= 1'b0;
      tmp_kind_reg <= 1'b0;
      mode_reg     <= 3'(MODE_DEFAULT);
      mag_res_reg  <= '0;
      tmp_res_reg  <= '0;
    end else begin
      st_reg       <= st_next;
      bit_reg      <= bit_next;
      shin_reg     <= shin_next;
      shout_reg    <= shout_next;
      dout_reg     <= dout_next;
      ack_reg      <= ack_next;
      is_cfg1_reg  <= is_cfg1_next;
      tmp_kind_reg <= tmp_kind_next;
      mode_reg     <= mode_next;
      mag_res_reg  <= mag_res_next;
      tmp_res_reg  <= tmp_res_next;
    end
  end

  // Reply is low while a started conversion runs, even with select released
  assign serial_reply_out = dout_reg & ~ack_reg;
  assign osr_mode         = mode_reg;
  assign converting       = conv_busy;
endmodule

/* File: design/fsc_pkg.sv */
package fsc_pkg;
  // Command bytes and config select values
  localparam logic [7:0] CMD_CFG1      = 8'h20;
  localparam logic [7:0] CMD_CFG2      = 8'h22;
  localparam logic [7:0] CMD_CONV_MAG  = 8'h44;
  localparam logic [7:0] CMD_CONV_TEMP = 8'h48;
  localparam logic [7:0] CMD_READ_MAG  = 8'h54;
  localparam logic [7:0] CMD_READ_TEMP = 8'h58;
  localparam logic [7:0] OSR_DEFAULT   = 8'h07;
  localparam logic [7:0] OSR_MAX_ALT   = 8'h05;

  // Frame geometry
  localparam int CMD_BITS  = 8;
  localparam int CFG_BITS  = 24;
  localparam int MAG_BITS  = 24;
  localparam int TEMP_BITS = 16;

  // Sampling times per mode in microseconds, mode 6 is the default
  localparam int CLK_HZ = 40_000_000;
  localparam int SAMPLE_US [0:6] = '{370, 650, 1220, 2340, 4580, 9070, 18040};
  localparam int MODE_DEFAULT = 6;

  // Cycles of clk for a time in microseconds, rounded up
  function automatic int us_to_cycles(input int us);
    longint p;
    p = longint'(us) * longint'(CLK_HZ);
    return int'((p + 64'd999_999) / 64'd1_000_000);
  endfunction

  typedef enum logic [1:0] {FSC_IDLE, FSC_CMD, FSC_DATA, FSC_DONE} fsc_state_t;
endpackage

/* File: verif/fsc_core_props.sv */
`timescale 1ns/1ps
module fsc_core_props
  import fsc_pkg::*;
#(
  parameter int MAG_W  = 24,
  parameter int TEMP_W = 16
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Serial pins
  input wire logic              sck,
  input wire logic              cs_n,
  input wire logic              serial_command_in,
  input wire logic              serial_reply_out,
  // Samples and status
  input wire logic [MAG_W-1:0]  adc_mag,
  input wire logic [TEMP_W-1:0] adc_temp,
  input wire logic [2:0]        osr_mode,
  input wire logic              converting
);
  // Conversion length per mode in clk cycles at 40 MHz
  localparam int EXP_CYC [0:6] = '{14800, 26000, 48800, 93600, 183200, 362800, 721600};
  logic [19:0] run_reg;
  logic [19:0] run_next;
  // Length of the running conversion, wide enough for the slowest mode
  always_comb begin
    run_next = converting ? run_reg + 20'h1 : 20'h0;
  end
  always_ff @(posedge clk) begin
    run_reg <= rst ? 20'h0 : run_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  reset_vals_a: assert property (disable iff (1'b0) rst |=> serial_reply_out && !converting)
    else $error("reply or converting wrong after reset");
  mode_range_a: assert property (osr_mode <= 3'h6)
    else $error("mode out of range");
  start_ack_a: assert property ($rose(converting) |-> ##[0:3] !serial_reply_out)
    else $error("no acknowledge at conversion start");
  conv_low_a: assert property (converting [*3] |-> !serial_reply_out)
    else $error("reply high while converting");
  done_rise_a: assert property ($fell(converting) |-> ##[0:3] serial_reply_out)
    else $error("reply not released at conversion end");
  mode_hold_a: assert property ($past(converting) && converting |-> $stable(osr_mode))
    else $error("mode changed during conversion");
  conv_time_a: assert property ($fell(converting) |->
      run_reg + 4 >= EXP_CYC[osr_mode] && run_reg <= EXP_CYC[osr_mode] + 4)
    else $error("conversion length does not match mode");
  idle_high_a: assert property ((cs_n && !converting) [*4] |-> serial_reply_out)
    else $error("reply low while idle");
  conv_start_c: cover property ($rose(converting));
  conv_end_c: cover property ($fell(converting));
  fast_mode_c: cover property (osr_mode == 3'h0);
endmodule

bind fsc_core fsc_core_props #(.MAG_W(MAG_W), .TEMP_W(TEMP_W)) u_props (.clk(clk), .rst(rst),
  .sck(sck), .cs_n(cs_n), .serial_command_in(serial_command_in),
  .serial_reply_out(serial_reply_out), .adc_mag(adc_mag), .adc_temp(adc_temp),
  .osr_mode(osr_mode), .converting(converting));

/* File: verif/fsc_core_tb_top.sv */
`timescale 1ns/1ps
module fsc_core_tb_top;
  import fsc_pkg::*;
  logic        clk = 1'b0;
  logic        rst;
  logic        sck;
  logic        cs_n;
  logic        serial_command_in;
  logic        reply;
  logic [23:0] adc_mag;
  logic [15:0] adc_temp;
  logic [2:0]  osr_mode;
  logic        converting;
  logic [31:0] rx;
  int          mismatches = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #12.5 clk = ~clk;
  fsc_core uut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n),
    .serial_command_in(serial_command_in),
    .serial_reply_out(reply), .adc_mag(adc_mag), .adc_temp(adc_temp),
    .osr_mode(osr_mode), .converting(converting));
  fsc_host_model host (.clk(clk), .serial_reply_out(reply), .sck(sck), .cs_n(cs_n),
    .serial_command_in(serial_command_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Whole run needs about 45000 cycles; the ceiling leaves margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Modes 3, illegal 6, default 7, 5 and fastest 0, then the second config
  task automatic t_config;
    logic [7:0] sel [5] = '{8'h03, 8'h06, 8'h07, 8'h05, 8'h00};
    logic [2:0] exp [5] = '{3'h3, 3'h3, 3'h6, 3'h5, 3'h0};
    for (int i = 0; i < 5; i++) begin
      host.xfer({8'h0, CMD_CFG1, 8'h0, sel[i]}, 24, rx);
      check(rx[16], 1'b0);
      check(osr_mode, exp[i]);
    end
    host.xfer({8'h0, CMD_CFG2, 16'h000f}, 24, rx);
  endtask
  // Set a mode, start, then a second start and a config while busy; time the run
  task automatic t_conv(input logic [7:0] cmd, input logic [7:0] other, input int mode);
    int t0;
    int len;
    len = SAMPLE_US[mode] * 40; // 40 clk per microsecond at 40 MHz
    host.xfer({8'h0, CMD_CFG1, 8'h0, 8'(mode)}, 24, rx);
    check(osr_mode, 3'(mode));
    adc_mag <= 24'ha5c3e1;
    adc_temp <= 16'h9b27;
    host.xfer({24'h0, cmd}, 8, rx);
    t0 = cyc;
    check(rx[0], 1'b0);
    check(converting, 1'b1);
    host.xfer({24'h0, other}, 8, rx);
    check(converting, 1'b1);
    host.xfer({8'h0, CMD_CFG1, 16'h0003}, 24, rx);
    check(osr_mode, 3'(mode));
    while (reply !== 1'b1 && cyc - t0 < len + 1000)
      @(posedge clk);
    check(cyc - t0 > len - 100 && cyc - t0 <= len, 1'b1);
    adc_mag <= 24'h5a3c1e;
    adc_temp <= 16'h64d8;
  endtask
  // Result must be the sample taken at conversion end, not the current input
  task automatic t_read(input logic [7:0] cmd, input int n, input logic [31:0] exp);
    host.xfer({24'h0, cmd} << n, 8 + n, rx);
    check(rx[n], 1'b0);
    check(rx & ((32'h1 << n) - 1), exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst <= 1'b1;
    adc_mag <= 24'h0;
    adc_temp <= 16'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(reply, 1'b1);
    check(osr_mode, 3'h6);
    t_config();
    t_conv(CMD_CONV_MAG, CMD_CONV_TEMP, 0);
    t_read(CMD_READ_MAG, 24, 32'ha5c3e1);
    t_conv(CMD_CONV_TEMP, CMD_CONV_MAG, 1);
    t_read(CMD_READ_TEMP, 16, 32'h9b27);
    complete_run();
  end
endmodule

/* File: verif/fsc_host_model.sv */
`timescale 1ns/1ps
module fsc_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  input wire logic serial_reply_out,
  output logic     sck,
  output logic     cs_n,
  output logic     serial_command_in
);
  // Idle bus: clock low, deselected
  initial begin
    sck <= 1'b0;
    cs_n <= 1'b1;
    serial_command_in <= 1'b0;
  end
  // Mode 0 frame, MSB first; slow half period keeps the device's synchronisers happy
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_command_in <= tx[i];
      repeat (8) @(posedge clk);
      sck <= 1'b1;
      rx = {rx[30:0], serial_reply_out};
      repeat (8) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    // Release select after the last bit; a start needs no wait for the end
    cs_n <= 1'b1;
    serial_command_in <= ~serial_command_in;
    repeat (8) @(posedge clk);
  endtask
endmodule
